// *** core/adcsr_top.sv ***
/*
 Digital readout and power-down control of a four-channel delta-sigma
 converter: drives the shared data-out/ready pin, serialises results,
 detects the held-high shift clock for sync and power-down, wakes on
 its falling edge and holds off after a channel change.
 Assumes the master clock is SYS_CLK, results arrive from filter logic
 on the same clock, and SCLK and channel selects come from pins.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// - power-down needs twenty high conversion periods
// - after four periods, one low pulse, hold
// - sixteen further periods then power-down
// - shift clock falling edge leaves power-down
// - first ready pulse 2318.5 periods after wake
// - 24-bit two's complement, MSB first
// - zero, 800000, 7fffff coding
// - load 6, low 6, high 6, then data
// - pin high 24 periods after data
// - sync pulse lasts three periods
// - power-down 6144.5 periods after last pulse
// - pin high 2043.5 periods after channel change
// - bits change on falling shift edges
// - short read keeps bit, long goes low
// - conversion cycle is 384 periods
module adcsr_top
    import adcsr_pkg::*;
#(
    parameter int PD_DELAY = adcsr_pkg::PD_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SCLK,
    input wire logic CHANNEL_SELECT_BIT0,
    input wire logic CHANNEL_SELECT_BIT1,
    input wire logic [adcsr_pkg::RESULT_W-1:0] RESULT_DATA,
    output logic RESULT_LOAD,
    output logic DATA_OUT_READY_PIN,
    output logic MODULATOR_RESET,
    output logic POWER_DOWN
);
    import adcsr_pkg::*;

    localparam logic [TIMER_W-1:0] PD_END = TIMER_W'(PD_DELAY - 1);
    localparam logic [TIMER_W-1:0] WAKE_END =
        TIMER_W'(WAKE_CYCLES - int'(POS_LOW) - 1);
    localparam logic [TIMER_W-1:0] SETTLE_END =
        TIMER_W'(SETTLE_CYCLES - int'(POS_LOW) - 1);
    localparam logic [TIMER_W-1:0] TIMER_MAX = '1;

    function automatic logic fell(input logic prev, input logic now);
        fell = prev & ~now;
    endfunction

    function automatic logic [TIMER_W-1:0] tick(
        input logic [TIMER_W-1:0] t
    );
        tick = (t == TIMER_MAX) ? t : t + 13'h0001;
    endfunction

    adcsr_state_type state_q;
    adcsr_state_type state_d;
    logic [POS_W-1:0] pos_q;
    logic [POS_W-1:0] pos_d;
    logic [HELD_W-1:0] held_q;
    logic [HELD_W-1:0] held_d;
    logic [TIMER_W-1:0] timer_q;
    logic [TIMER_W-1:0] timer_d;
    logic pin_q;
    logic pin_d;
    logic modrst_q;
    logic modrst_d;
    logic pd_q;
    logic pd_d;
    logic sclk_m_q;
    logic sclk_s_q;
    logic sclk_p_q;
    logic [1:0] chan_m_q;
    logic [1:0] chan_s_q;
    logic [1:0] chan_p_q;
    logic sclk_fall;
    logic chan_change;
    logic load;
    logic dout_bit;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sclk_m_q <= 1'b0;
            sclk_s_q <= 1'b0;
            sclk_p_q <= 1'b0;
            chan_m_q <= 2'h0;
            chan_s_q <= 2'h0;
            chan_p_q <= 2'h0;
        end else begin
            sclk_m_q <= SCLK;
            sclk_s_q <= sclk_m_q;
            sclk_p_q <= sclk_s_q;
            chan_m_q <= {CHANNEL_SELECT_BIT1, CHANNEL_SELECT_BIT0};
            chan_s_q <= chan_m_q;
            chan_p_q <= chan_s_q;
        end
    end

    assign sclk_fall = fell(sclk_p_q, sclk_s_q);
    assign chan_change = chan_s_q != chan_p_q;

    // next bit on falling shift edge
    adcsr_shifter #(
        .W(RESULT_W)
    ) u_shifter (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .load(load),
        .data(RESULT_DATA),
        .shift(sclk_fall && state_q == ST_RUN && pos_q >= POS_DOUT
            && pos_q < POS_TAIL),
        .bit_q(dout_bit)
    );

    always_comb begin
        state_d = state_q;
        pos_d = pos_q;
        held_d = held_q;
        timer_d = timer_q;
        modrst_d = modrst_q;
        pd_d = pd_q;
        load = 1'b0;
        unique case (state_q)
            ST_RUN: begin
                pos_d = (pos_q == POS_LAST) ? POS_LOAD : pos_q + 9'h001;
                load = pos_q == POS_LOAD;
                if (!sclk_s_q) begin
                    held_d = '0;
                end else if (pos_q == POS_LAST && held_q < HELD_SYNC) begin
                    held_d = held_q + 5'h01;
                end
                if (held_q == HELD_SYNC) begin
                    state_d = ST_SYNC;
                    timer_d = '0;
                    modrst_d = 1'b1;
                end else if (chan_change) begin
                    state_d = ST_SETTLE;
                    timer_d = '0;
                    pos_d = POS_LOAD;
                end
            end
            ST_SYNC: begin
                timer_d = tick(timer_q);
                if (sclk_fall) begin
                    state_d = ST_WAKE;
                    timer_d = '0;
                    modrst_d = 1'b0;
                    held_d = '0;
                end else if (timer_q == PD_END) begin
                    // delay counted from the sync pulse
                    state_d = ST_PDOWN;
                    held_d = HELD_SYNC + HELD_EXTRA;
                    pd_d = 1'b1;
                end
            end
            ST_PDOWN: begin
                // wake on shift clock falling edge
                if (sclk_fall) begin
                    state_d = ST_WAKE;
                    timer_d = '0;
                    modrst_d = 1'b0;
                    pd_d = 1'b0;
                    held_d = '0;
                end
            end
            ST_WAKE: begin
                timer_d = tick(timer_q);
                // first low pulse at 2319 cycles
                if (timer_q == WAKE_END) begin
                    state_d = ST_RUN;
                    pos_d = POS_LOAD;
                end
            end
            ST_SETTLE: begin
                timer_d = tick(timer_q);
                // settle hold restarts on each change
                if (chan_change) begin
                    timer_d = '0;
                end else if (timer_q == SETTLE_END) begin
                    state_d = ST_RUN;
                    pos_d = POS_LOAD;
                end
            end
            default: begin
                state_d = ST_RUN;
                pos_d = POS_LOAD;
                timer_d = '0;
                modrst_d = 1'b0;
                pd_d = 1'b0;
            end
        endcase
    end

    always_comb begin
        pin_d = 1'b1;
        unique case (state_q)
            ST_RUN: begin
                if (pos_q >= POS_LOW && pos_q < POS_HIGH) begin
                    pin_d = 1'b0;
                end else if (pos_q >= POS_DOUT && pos_q < POS_TAIL) begin
                    pin_d = dout_bit;
                end else begin
                    pin_d = 1'b1;
                end
            end
            ST_SYNC: begin
                pin_d = timer_q >= SYNC_PULSE;
            end
            default: begin
                pin_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_RUN;
            pos_q <= POS_LOAD;
            held_q <= '0;
            timer_q <= '0;
            pin_q <= 1'b1;
            modrst_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pos_q <= pos_d;
            held_q <= held_d;
            timer_q <= timer_d;
            pin_q <= pin_d;
            modrst_q <= modrst_d;
            pd_q <= pd_d;
        end
    end

    assign RESULT_LOAD = load;
    assign DATA_OUT_READY_PIN = pin_q;
    assign MODULATOR_RESET = modrst_q;
    assign POWER_DOWN = pd_q;
endmodule

`default_nettype wire

// *** core/adcsr_pkg.sv ***
/*
 Shared constants and types for the converter serial readout and
 power-down control: conversion cycle layout, held-clock thresholds,
 timing figures and their cycle counts, result coding.
 Assumes a single master clock of 100 MHz that is also SYS_CLK.
*/
`default_nettype none

package adcsr_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int RESULT_W = 24;
    localparam int POS_W = 9;
    localparam int TIMER_W = 13;
    localparam int HELD_W = 5;

    // Positions inside one 384-period conversion cycle
    localparam logic [POS_W-1:0] POS_LOAD = 9'h000;
    localparam logic [POS_W-1:0] POS_LOW = 9'h006;
    localparam logic [POS_W-1:0] POS_HIGH = 9'h00c;
    localparam logic [POS_W-1:0] POS_DOUT = 9'h012;
    localparam logic [POS_W-1:0] POS_TAIL = 9'h168;
    localparam logic [POS_W-1:0] POS_LAST = 9'h17f;

    // Conversion periods with the shift clock held high
    localparam logic [HELD_W-1:0] HELD_SYNC = 5'h04;
    localparam logic [HELD_W-1:0] HELD_EXTRA = 5'h10;

    localparam logic [TIMER_W-1:0] SYNC_PULSE = 13'h0003;

    // Times in ns, half master periods included
    localparam int WAKE_TIME_NS = 23185;
    localparam int PD_TIME_NS = 61445;
    localparam int SETTLE_TIME_NS = 20435;

    // Least times round up to whole cycles
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int PD_CYCLES = (PD_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;

    // Two's complement result codes
    localparam logic [RESULT_W-1:0] CODE_ZERO = 24'h000000;
    localparam logic [RESULT_W-1:0] CODE_NEG_FS = 24'h800000;
    localparam logic [RESULT_W-1:0] CODE_POS_FS = 24'h7fffff;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_SYNC = 5'h02,
        ST_PDOWN = 5'h04,
        ST_WAKE = 5'h08,
        ST_SETTLE = 5'h10
    } adcsr_state_type;

endpackage

`default_nettype wire

// *** core/adcsr_shifter.sv ***
/*
 Result shift register: loads a conversion word and moves it out MSB
 first, one bit per shift strobe, then holds the pin level low.
 Assumes load and shift are one-cycle strobes on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module adcsr_shifter #(
    parameter int W = 24
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] data,
    input wire logic shift,
    output logic bit_q
);
    logic [W-1:0] sr_q;
    logic [W-1:0] sr_d;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic bit_d;

    localparam logic [5:0] LAST = 6'(W - 1);

    always_comb begin
        sr_d = sr_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        if (load) begin
            sr_d = data;
            cnt_d = 6'h00;
            bit_d = data[W-1];
        end else if (shift) begin
            if (cnt_q < LAST) begin
                sr_d = {sr_q[W-2:0], 1'b0};
                cnt_d = cnt_q + 6'h01;
                bit_d = sr_q[W-2];
            end else begin
                cnt_d = LAST + 6'h01;
                bit_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_q <= '0;
            cnt_q <= 6'h00;
            bit_q <= 1'b0;
        end else begin
            sr_q <= sr_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
        end
    end
endmodule

`default_nettype wire

// *** sim/adcsr_chk.sv ***
/*
 Port checker for the readout and power-down block.
 Assumes binding to adcsr_top with PD_DELAY passed on.
*/
`timescale 1ns/1ps
`default_nettype none

module adcsr_chk #(
    parameter int PD_DELAY = 6145
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SCLK,
    input wire logic CHANNEL_SELECT_BIT0,
    input wire logic CHANNEL_SELECT_BIT1,
    input wire logic RESULT_LOAD,
    input wire logic DATA_OUT_READY_PIN,
    input wire logic MODULATOR_RESET,
    input wire logic POWER_DOWN
);
    logic [12:0] gap_q, gap_d, mrc_q, mrc_d, evc_q, evc_d;
    logic [1:0] ch_q, ch_d;
    logic dty_q, dty_d, wk_q, wk_d, st_q, st_d, mr_q, pin_q;
    logic chg, mr_fell, pin_fell, pin, mr;

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    assign pin = DATA_OUT_READY_PIN;
    assign mr = MODULATOR_RESET;

    // Cycles since load, since sync entry and since wake or change
    always_comb begin
        ch_d = {CHANNEL_SELECT_BIT1, CHANNEL_SELECT_BIT0};
        chg = ch_d != ch_q;
        mr_fell = mr_q && !mr;
        pin_fell = pin_q && !pin;
        gap_d = RESULT_LOAD ? 13'h0001 : gap_q + 13'h0001;
        mrc_d = mr ? mrc_q + 13'h0001 : 13'h0000;
        evc_d = (mr_fell || chg) ? 13'h0001 : evc_q + 13'h0001;
        dty_d = (dty_q && !RESULT_LOAD) || mr || chg;
        wk_d = mr_fell || (wk_q && !pin_fell);
        st_d = (chg && !mr) || (st_q && !pin_fell && !mr_fell);
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {gap_q, mrc_q, evc_q} <= '0;
            {ch_q, dty_q, wk_q, st_q, mr_q, pin_q} <= 7'h11;
        end else begin
            {gap_q, mrc_q, evc_q} <= {gap_d, mrc_d, evc_d};
            {ch_q, dty_q, wk_q, st_q} <= {ch_d, dty_d, wk_d, st_d};
            {mr_q, pin_q} <= {mr, pin};
        end
    end

    a_ready_pulse: assert property (RESULT_LOAD && !SCLK |->
        ##1 pin[*6] ##1 !pin[*6] ##1 pin[*6]) else $error("bad ready");
    a_cycle_len: assert property (RESULT_LOAD && !dty_q |->
        gap_q == 13'h0180) else $error("bad cycle length");
    a_tail_high: assert property (!dty_q && gap_q > 13'h0168 &&
        gap_q < 13'h0180 |-> pin) else $error("bad tail");
    a_sync_pulse: assert property ($rose(mr) |->
        ##1 !pin[*3] ##1 pin[*8]) else $error("bad sync pulse");
    a_pd_delay: assert property ($rose(POWER_DOWN) |-> mr &&
        mrc_q + 1 >= PD_DELAY && mrc_q <= PD_DELAY + 1) else $error("bad pd");
    a_wake_drop: assert property ($fell(SCLK) && mr |->
        ##[2:5] !mr && !POWER_DOWN) else $error("no wake");
    a_wake_time: assert property (pin_fell && wk_q |->
        evc_q >= 13'h090a && evc_q <= 13'h0912) else $error("bad wake");
    a_settle_time: assert property (pin_fell && st_q |->
        evc_q >= 13'h07fa && evc_q <= 13'h0804) else $error("bad settle");

    c_power_down: cover property ($rose(POWER_DOWN));
    c_wake: cover property (pin_fell && wk_q);
    c_settle: cover property (pin_fell && st_q);
endmodule

`default_nettype wire

// *** sim/adcsr_host.sv ***
/*
 Host model: waits for the ready pulse, clocks out n_rd bits, then
 samples the pin once more just before the tail and reports all bits.
 Assumes the master clock of the block and results every 384 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module adcsr_host (
    input wire logic clk,
    input wire logic hold_hi,
    input wire logic [4:0] n_rd,
    input wire logic pin,
    output logic sclk,
    output logic done,
    output logic [31:0] res
);
    logic sck;
    int lo;
    int n;

    // idles low, held high on request
    assign sclk = sck | hold_hi;

    initial begin
        sck = 1'b0;
        done = 1'b0;
        res = '0;
        lo = 0;
        forever begin
            @(negedge clk);
            done = 1'b0;
            lo = (!hold_hi && !pin) ? lo + 1 : 0;
            // read after a ready pulse, sample on rise
            if (lo == 6) begin
                n = n_rd;
                // Each read starts from an empty word
                res = '0;
                repeat (7) @(negedge clk);
                repeat (n) begin
                    sck = 1'b1;
                    res = {res[30:0], pin};
                    repeat (6) @(negedge clk);
                    sck = 1'b0;
                    repeat (6) @(negedge clk);
                end
                repeat (338 - 12 * n) @(negedge clk);
                res = {res[30:0], pin};
                done = 1'b1;
                lo = 0;
            end
        end
    end
endmodule

`default_nettype wire

// *** sim/adcsr_top_tb.sv ***
/*
 Testbench: words of random read length and channel changes read back
 through the host model; sync and power-down with wake-up checked on the outputs.
 Assumes the checker is bound below and PD_DELAY is shortened.
*/
`timescale 1ns/1ps
`default_nettype none

module adcsr_top_tb;
    import adcsr_pkg::*;
    localparam int PD_DELAY = 1000;
    logic sys_clk, rst_n, sclk, ch0, ch1, load, pin, mres, pdown;
    logic [RESULT_W-1:0] data, word;
    logic [4:0] n_rd;
    logic hold_hi, done, chg;
    logic [31:0] res, e;
    logic [31:0] q[$];
    int bad_count, cmp_count, idx;

    adcsr_top #(.PD_DELAY(PD_DELAY)) i_adcsr_top (.SYS_CLK(sys_clk),
        .RST_N(rst_n), .SCLK(sclk), .CHANNEL_SELECT_BIT0(ch0),
        .CHANNEL_SELECT_BIT1(ch1), .RESULT_DATA(data), .RESULT_LOAD(load),
        .DATA_OUT_READY_PIN(pin), .MODULATOR_RESET(mres), .POWER_DOWN(pdown));
    adcsr_host i_adcsr_host (.clk(sys_clk), .hold_hi, .n_rd, .pin, .sclk,
        .done, .res);

    task automatic results();
        $display("checks %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // Bounded wait for done, sync hold or power-down to reach v
    task automatic wt(input int s, input logic v, input int lim);
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while ((s == 0 ? done : s == 1 ? mres : pdown) !== v && i < lim);
        if (i >= lim) begin
            bad_count++;
            results();
        end
        @(negedge sys_clk);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // word loaded, read length chosen, readback noted
    always @(negedge sys_clk) begin
        if (load) begin
            word = data;
            chg = 1'b1;
        end else if (chg) begin
            chg = 1'b0;
            n_rd = 5'($urandom_range(27, 0));
            e = n_rd > 24 ? {8'h00, word} << (n_rd - 24)
                : {8'h00, word} >> (24 - n_rd);
            e = {e[30:0], n_rd < 24 ? word[23 - n_rd] : 1'b0};
            if (!hold_hi) q.push_back(e);
            idx++;
            data = idx == 1 ? CODE_NEG_FS : idx == 2 ? CODE_POS_FS
                : RESULT_W'($urandom);
        end
    end

    always @(posedge sys_clk) begin
        if (done === 1'b1) begin
            chk("word", res, q.size() > 0 ? q.pop_front() : 'x);
        end
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        results();
    end

    initial begin
        {rst_n, ch0, ch1, hold_hi, chg} = 5'h00;
        n_rd = 5'h18;
        data = CODE_ZERO;
        {idx, bad_count, cmp_count} = '0;
        void'($urandom(44452));
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) wt(0, 1'b1, 3000);
        for (int c = 1; c < 4; c += 2) begin
            {ch1, ch0} = 2'(c);
            repeat (2) wt(0, 1'b1, 3000);
        end
        for (int p = 0; p < 2; p++) begin
            hold_hi = 1'b1;
            wt(1, 1'b1, 2000);
            if (p == 1) begin
                wt(2, 1'b1, PD_DELAY + 20);
            end else begin
                repeat (20) @(negedge sys_clk);
            end
            chk("power down", {31'h0, pdown}, 32'(p));
            chk("held pin", {31'h0, pin}, 32'h1);
            hold_hi = 1'b0;
            wt(1, 1'b0, 10);
            chk("woken", {31'h0, pdown}, 32'h0);
            repeat (2) wt(0, 1'b1, 3000);
        end
        chk("unread words", q.size(), 32'h0);
        results();
    end
endmodule

bind adcsr_top adcsr_chk #(.PD_DELAY(PD_DELAY)) i_adcsr_chk (.SYS_CLK,
    .RST_N, .SCLK, .CHANNEL_SELECT_BIT0, .CHANNEL_SELECT_BIT1,
    .RESULT_LOAD, .DATA_OUT_READY_PIN, .MODULATOR_RESET, .POWER_DOWN);

`default_nettype wire
